// ==== ssd_cfg.svh ====
`ifndef SSD_CFG_SVH
`define SSD_CFG_SVH

`define SSD_ESC_BYTE 8'h0f
`define SSD_SHIFT_ONE 7'h68
`define SSD_SHIFT_CNT 7'h69
`define SSD_SHIFT_IMM 7'h60
`define SSD_DSHR_IMM 8'hac
`define SSD_DSHR_CNT 8'had
`define SSD_GRP_TABLE 8'h01
`define SSD_GRP_SELECTOR 8'h00
`define SSD_SET_CARRY 8'hf9
`define SSD_SET_DIR 8'hfd
`define SSD_SET_INTEN 8'hfb
`define SSD_STRING_WR 7'h55
`define SSD_SUB_TO_RM 7'h14
`define SSD_SUB_TO_REG 7'h15

`define SSD_SEL_RSHIFT 3'h5
`define SSD_SEL_INT_TABLE 3'h1
`define SSD_SEL_LOCAL 3'h0
`define SSD_SEL_TASK 3'h1
`define SSD_SEL_MACHINE 3'h4
`define SSD_MOD_REG 2'h3

`define SSD_CLK_1 4'h1
`define SSD_CLK_2 4'h2
`define SSD_CLK_3 4'h3
`define SSD_CLK_4 4'h4
`define SSD_CLK_5 4'h5
`define SSD_CLK_10 4'ha
`define SSD_PEN_0 3'h0
`define SSD_PEN_2 3'h2
`define SSD_PEN_5 3'h5
`define SSD_PEN_6 3'h6

`endif

// ==== ssd_decode.sv ====
// What this block does
// - right shift: reg field 101, six first bytes
// - shift costs 3/2 reg, 4+6 memory
// - double right shift after escape, AC/AD
// - double shift costs 2,3+6,3,4+5
// - int table store: 0F 01, memory, 001
// - local selector store: 0F 00 000, 2/3
// - machine word store: selector 100, 2/3
// - F9 sets carry, 2 clocks
// - FD sets direction downward, 2 clocks
// - FB sets interrupt enable, 2 clocks
// - string write, size from w, 5 clocks
// - task selector store: 0F 00 001, 2/3
`default_nettype none
`include "ssd_cfg.svh"
module ssd_decode
  import ssd_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic rst, // synchronous reset, high
  input wire logic instValid, // opcode bytes valid this cycle
  input wire logic [7:0] opByte0, // first opcode byte
  input wire logic [7:0] opByte1, // second byte
  input wire logic [7:0] opByte2, // third byte
  input wire logic opSize32, // current operand size is 32 bits
  input wire logic lockPrefix, // locked access
  input wire logic [2:0] flagClear, // clears: 0 carry, 1 direction, 2 int enable
  output logic decValid_reg, // one-cycle result strobe
  output logic decIllegal_reg, // bytes not in this range
  output ssd_op_t opClass_reg, // decoded class
  output ssd_count_t countSrc_reg, // shift count source
  output ssd_size_t opSize_reg, // operand size
  output logic memOperand_reg, // memory destination or source
  output logic imm8Follows_reg, // 8-bit immediate trails
  output logic [3:0] hitClocks_reg, // clocks on cache hit
  output logic [2:0] missPenalty_reg, // extra clocks on miss
  output logic carryFlag_reg, // carry flag
  output logic directionFlag_reg, // string step downward
  output logic intEnableFlag_reg // interrupt enable flag
);
  ssd_modrm_if mrShort ();
  ssd_modrm_if mrLong ();

  // one splitter for single-byte opcodes, one behind the escape
  assign mrShort.rawByte = opByte1;
  assign mrLong.rawByte = opByte2;
  ssd_modrm_split uSplitShort (.mr(mrShort));
  ssd_modrm_split uSplitLong (.mr(mrLong));

  ssd_op_t opClass_next;
  ssd_count_t countSrc_next;
  ssd_size_t opSize_next;
  logic illegal_next;
  logic mem_next;
  logic imm8_next;
  logic [3:0] hitClocks_next;
  logic [2:0] missPenalty_next;
  logic isEsc;

  assign isEsc = (opByte0 == `SSD_ESC_BYTE);

  always_comb begin
    opClass_next = SSD_OP_NONE;
    countSrc_next = SSD_CNT_NONE;
    opSize_next = SSD_SZ_BYTE;
    illegal_next = 1'b0;
    mem_next = 1'b0;
    imm8_next = 1'b0;
    hitClocks_next = `SSD_CLK_1;
    missPenalty_next = `SSD_PEN_0;
    // size from the w bit; forms without w pick this up harmlessly
    if (opByte0[0]) begin
      opSize_next = opSize32 ? SSD_SZ_DWORD : SSD_SZ_WORD;
    end
    if (isEsc) begin
      // escape forms default to full width at current operand size
      opSize_next = opSize32 ? SSD_SZ_DWORD : SSD_SZ_WORD;
      mem_next = !mrLong.isReg;
      if (opByte1 == `SSD_DSHR_IMM || opByte1 == `SSD_DSHR_CNT) begin
        opClass_next = SSD_OP_DSHR;
        if (opByte1 == `SSD_DSHR_IMM) begin
          countSrc_next = SSD_CNT_IMM;
          imm8_next = 1'b1;
          hitClocks_next = mrLong.isReg ? `SSD_CLK_2 : `SSD_CLK_3;
          missPenalty_next = mrLong.isReg ? `SSD_PEN_0 : `SSD_PEN_6;
        end else begin
          countSrc_next = SSD_CNT_COUNT_REG;
          hitClocks_next = mrLong.isReg ? `SSD_CLK_3 : `SSD_CLK_4;
          missPenalty_next = mrLong.isReg ? `SSD_PEN_0 : `SSD_PEN_5;
        end
      end else if (opByte1 == `SSD_GRP_TABLE) begin
        if (mrLong.regSel == `SSD_SEL_INT_TABLE && !mrLong.isReg) begin
          opClass_next = SSD_OP_INT_TABLE;
          hitClocks_next = `SSD_CLK_10;
        end else if (mrLong.regSel == `SSD_SEL_MACHINE) begin
          opClass_next = SSD_OP_MACHINE_WORD;
          opSize_next = SSD_SZ_WORD;
          hitClocks_next = mrLong.isReg ? `SSD_CLK_2 : `SSD_CLK_3;
        end else begin
          illegal_next = 1'b1;
        end
      end else if (opByte1 == `SSD_GRP_SELECTOR) begin
        // selectors are 16 bits wide whatever the operand size
        opSize_next = SSD_SZ_WORD;
        hitClocks_next = mrLong.isReg ? `SSD_CLK_2 : `SSD_CLK_3;
        if (mrLong.regSel == `SSD_SEL_LOCAL) begin
          opClass_next = SSD_OP_LOCAL_SEL;
        end else if (mrLong.regSel == `SSD_SEL_TASK) begin
          opClass_next = SSD_OP_TASK_SEL;
        end else begin
          illegal_next = 1'b1;
          hitClocks_next = `SSD_CLK_1;
        end
      end else begin
        illegal_next = 1'b1;
        mem_next = 1'b0;
      end
    end else if (opByte0[7:1] == `SSD_SHIFT_ONE || opByte0[7:1] == `SSD_SHIFT_CNT
                 || opByte0[7:1] == `SSD_SHIFT_IMM) begin
      if (mrShort.regSel == `SSD_SEL_RSHIFT) begin
        opClass_next = SSD_OP_RSHIFT;
        mem_next = !mrShort.isReg;
        if (opByte0[7:1] == `SSD_SHIFT_ONE) begin
          countSrc_next = SSD_CNT_ONE;
        end else if (opByte0[7:1] == `SSD_SHIFT_CNT) begin
          countSrc_next = SSD_CNT_COUNT_REG;
        end else begin
          countSrc_next = SSD_CNT_IMM;
          imm8_next = 1'b1;
        end
        if (!mrShort.isReg) begin
          hitClocks_next = `SSD_CLK_4;
          missPenalty_next = `SSD_PEN_6;
        end else if (countSrc_next == SSD_CNT_IMM) begin
          hitClocks_next = `SSD_CLK_2;
        end else begin
          hitClocks_next = `SSD_CLK_3;
        end
      end else begin
        illegal_next = 1'b1;
      end
    end else if (opByte0 == `SSD_SET_CARRY) begin
      opClass_next = SSD_OP_SET_CARRY;
      hitClocks_next = `SSD_CLK_2;
    end else if (opByte0 == `SSD_SET_DIR) begin
      opClass_next = SSD_OP_SET_DIR;
      hitClocks_next = `SSD_CLK_2;
    end else if (opByte0 == `SSD_SET_INTEN) begin
      opClass_next = SSD_OP_SET_INTEN;
      hitClocks_next = `SSD_CLK_2;
    end else if (opByte0[7:1] == `SSD_STRING_WR) begin
      opClass_next = SSD_OP_STRING_WR;
      mem_next = 1'b1;
      hitClocks_next = `SSD_CLK_5;
    end else if (opByte0[7:1] == `SSD_SUB_TO_RM || opByte0[7:1] == `SSD_SUB_TO_REG) begin
      opClass_next = SSD_OP_SUB;
      mem_next = !mrShort.isReg;
      if (mrShort.isReg) begin
        hitClocks_next = `SSD_CLK_1;
      end else if (opByte0[7:1] == `SSD_SUB_TO_REG) begin
        hitClocks_next = `SSD_CLK_2;
        missPenalty_next = `SSD_PEN_2;
      end else begin
        hitClocks_next = `SSD_CLK_3;
        // locked read-modify-write keeps the line, so a smaller miss cost
        missPenalty_next = lockPrefix ? `SSD_PEN_2 : `SSD_PEN_6;
      end
    end else begin
      illegal_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      decValid_reg <= 1'b0;
      decIllegal_reg <= 1'b0;
      opClass_reg <= SSD_OP_NONE;
      countSrc_reg <= SSD_CNT_NONE;
      opSize_reg <= SSD_SZ_BYTE;
      memOperand_reg <= 1'b0;
      imm8Follows_reg <= 1'b0;
      hitClocks_reg <= `SSD_CLK_1;
      missPenalty_reg <= `SSD_PEN_0;
    end else begin
      decValid_reg <= instValid;
      if (instValid) begin
        decIllegal_reg <= illegal_next;
        opClass_reg <= opClass_next;
        countSrc_reg <= countSrc_next;
        opSize_reg <= opSize_next;
        memOperand_reg <= mem_next;
        imm8Follows_reg <= imm8_next;
        hitClocks_reg <= hitClocks_next;
        missPenalty_reg <= missPenalty_next;
      end
    end
  end

  // a set in the same cycle as a clear wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      carryFlag_reg <= 1'b0;
      directionFlag_reg <= 1'b0;
      intEnableFlag_reg <= 1'b0;
    end else begin
      if (instValid && opClass_next == SSD_OP_SET_CARRY) begin
        carryFlag_reg <= 1'b1;
      end else if (flagClear[0]) begin
        carryFlag_reg <= 1'b0;
      end
      if (instValid && opClass_next == SSD_OP_SET_DIR) begin
        directionFlag_reg <= 1'b1;
      end else if (flagClear[1]) begin
        directionFlag_reg <= 1'b0;
      end
      if (instValid && opClass_next == SSD_OP_SET_INTEN) begin
        intEnableFlag_reg <= 1'b1;
      end else if (flagClear[2]) begin
        intEnableFlag_reg <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== ssd_decode_checker.sv ====
`default_nettype none
module ssd_decode_checker
  import ssd_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic instValid, // request
  input wire logic [7:0] opByte0, // byte 0
  input wire logic [7:0] opByte1, // byte 1
  input wire logic opSize32, // size
  input wire logic decValid_reg, // strobe
  input wire logic decIllegal_reg, // illegal
  input wire ssd_op_t opClass_reg, // class
  input wire ssd_count_t countSrc_reg, // count
  input wire ssd_size_t opSize_reg, // size out
  input wire logic imm8Follows_reg, // imm
  input wire logic [3:0] hitClocks_reg, // hit
  input wire logic [2:0] missPenalty_reg, // miss
  input wire logic carryFlag_reg, // carry
  input wire logic directionFlag_reg, // dir
  input wire logic intEnableFlag_reg // int en
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_VALID_PULSE: assert property (instValid |=> decValid_reg)
    else $error("result strobe missing");
  AST_IDLE_HOLD: assert property (!instValid |=> !decValid_reg && $stable(opClass_reg)
    && $stable(hitClocks_reg)) else $error("idle cycle changed result");
  AST_SET_CARRY: assert property (instValid && opByte0 == 8'hf9 |=> carryFlag_reg
    && opClass_reg == SSD_OP_SET_CARRY && hitClocks_reg == 4'h2) else $error("carry set");
  AST_SET_DIR: assert property (instValid && opByte0 == 8'hfd |=> directionFlag_reg
    && opClass_reg == SSD_OP_SET_DIR && hitClocks_reg == 4'h2) else $error("dir set");
  AST_SET_INTEN: assert property (instValid && opByte0 == 8'hfb |=> intEnableFlag_reg
    && opClass_reg == SSD_OP_SET_INTEN && hitClocks_reg == 4'h2) else $error("inten set");
  AST_RSHIFT_MEM: assert property (instValid && opByte0[7:1] == 7'h68
    && opByte1[5:3] == 3'h5 && opByte1[7:6] != 2'h3 |=> opClass_reg == SSD_OP_RSHIFT
    && hitClocks_reg == 4'h4 && missPenalty_reg == 3'h6 && countSrc_reg == SSD_CNT_ONE)
    else $error("shift memory cost");
  AST_RSHIFT_IMM: assert property (instValid && opByte0[7:1] == 7'h60
    && opByte1[7:3] == 5'h1d |=> hitClocks_reg == 4'h2 && imm8Follows_reg
    && countSrc_reg == SSD_CNT_IMM) else $error("shift immediate");
  AST_STRING_SIZE: assert property (instValid && opByte0[7:1] == 7'h55
    |=> opClass_reg == SSD_OP_STRING_WR && hitClocks_reg == 4'h5 && opSize_reg ==
    ($past(opByte0[0]) ? ($past(opSize32) ? SSD_SZ_DWORD : SSD_SZ_WORD) : SSD_SZ_BYTE))
    else $error("string write");
  AST_SUB_REG: assert property (instValid && opByte0[7:2] == 6'h0a
    && opByte1[7:6] == 2'h3 |=> opClass_reg == SSD_OP_SUB && hitClocks_reg == 4'h1
    && missPenalty_reg == 3'h0) else $error("register subtract");
  cover property (instValid && opByte0 == 8'h0f);
  cover property (decValid_reg && decIllegal_reg);
  cover property (instValid && opByte0[7:1] == 7'h55);
endmodule
bind ssd_decode ssd_decode_checker ssd_decode_checker_inst (.core_clk, .rst, .instValid,
  .opByte0, .opByte1, .opSize32, .decValid_reg, .decIllegal_reg, .opClass_reg,
  .countSrc_reg, .opSize_reg, .imm8Follows_reg, .hitClocks_reg, .missPenalty_reg,
  .carryFlag_reg, .directionFlag_reg, .intEnableFlag_reg);
`default_nettype wire

// ==== ssd_decode_tb.sv ====
`default_nettype none
module ssd_decode_tb
  import ssd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, rst = 1'b1, instValid = 1'b0, opSize32 = 1'b0, lockPrefix = 1'b0;
  logic [7:0] opByte0 = 8'h00, opByte1 = 8'h00, opByte2 = 8'h00, pa, pb;
  logic [2:0] flagClear = 3'h0, fl = 3'h0, missPenalty_reg;
  logic decValid_reg, decIllegal_reg, memOperand_reg, imm8Follows_reg;
  logic carryFlag_reg, directionFlag_reg, intEnableFlag_reg;
  ssd_op_t opClass_reg;
  ssd_count_t countSrc_reg;
  ssd_size_t opSize_reg;
  logic [3:0] hitClocks_reg;
  logic [27:0] ev = 28'h0, em = 28'h0;
  logic ei = 1'b0;
  logic [28:0] got;
  logic [31:0] seed = 32'h00015e0f, r;
  int miscompares = 0, n_compared = 0, cyc = 0;
  localparam logic [7:0] OPS [17] = '{8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hc0, 8'hc1, 8'h0f,
    8'hf9, 8'hfd, 8'hfb, 8'haa, 8'hab, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h90};
  localparam logic [7:0] ESC2 [5] = '{8'hac, 8'had, 8'h01, 8'h00, 8'h05};
  localparam logic [23:0] CORNER [15] = '{24'h0f01c8, 24'h0f0108, 24'h0f00d0, 24'h0f01e0,
    24'h0f0120, 24'h0f00c8, 24'h0f0000, 24'hd0e000, 24'hc1e800, 24'h0fad00, 24'h290000,
    24'h280000, 24'hf90000, 24'hfd0000, 24'hfb0000};
  always #20 core_clk = ~core_clk;
  ssd_decode ssd_decode_inst (.core_clk, .rst, .instValid, .opByte0, .opByte1, .opByte2,
    .opSize32, .lockPrefix, .flagClear, .decValid_reg, .decIllegal_reg, .opClass_reg,
    .countSrc_reg, .opSize_reg, .memOperand_reg, .imm8Follows_reg, .hitClocks_reg,
    .missPenalty_reg, .carryFlag_reg, .directionFlag_reg, .intEnableFlag_reg);
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [28:0] g, e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_flags(input logic [2:0] g, e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t flags got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // layout: illegal, class, hit, penalty, memory, size, count; em masks unchecked fields
  function automatic logic [27:0] expect_dec(input logic [7:0] a, b, c, input logic s, l);
    logic [7:0] m;
    logic rg;
    ssd_size_t w;
    m = (a == 8'h0f) ? c : b;
    rg = m[7:6] == 2'h3;
    w = a[0] ? (s ? SSD_SZ_DWORD : SSD_SZ_WORD) : SSD_SZ_BYTE;
    em = 28'hfffff00;
    expect_dec = {1'b1, SSD_OP_NONE, 4'h1, 3'h0, 8'h00};
    if (a == 8'h0f) begin
      if (b[7:1] == 7'h56) begin
        em = 28'hfffffff;
        expect_dec = {1'b0, SSD_OP_DSHR, (b[0] ? 4'h3 : 4'h2) + {3'h0, !rg},
          rg ? 3'h0 : 3'h6 - {2'h0, b[0]}, !rg, s ? SSD_SZ_DWORD : SSD_SZ_WORD,
          b[0] ? SSD_CNT_COUNT_REG : SSD_CNT_IMM};
      end else if (b == 8'h01 && m[5:3] == 3'h1 && !rg) begin
        em = 28'hfffff80;
        expect_dec = {1'b0, SSD_OP_INT_TABLE, 4'ha, 3'h0, 8'h80};
      end else if ((b == 8'h01 && m[5:3] == 3'h4) || (b == 8'h00 && m[5:4] == 2'h0)) begin
        em = 28'hffffff0;
        expect_dec = {1'b0, b[0] ? SSD_OP_MACHINE_WORD : (m[3] ? SSD_OP_TASK_SEL :
          SSD_OP_LOCAL_SEL), 4'h2 + {3'h0, !rg}, 3'h0, !rg, SSD_SZ_WORD, 4'h0};
      end
    end else if ((a[7:1] == 7'h68 || a[7:1] == 7'h69 || a[7:1] == 7'h60) && b[5:3] == 3'h5) begin
      em = 28'hfffffff;
      expect_dec = {1'b0, SSD_OP_RSHIFT, rg ? (a[7:1] == 7'h60 ? 4'h2 : 4'h3) : 4'h4,
        rg ? 3'h0 : 3'h6, !rg, w, a[4] ? (a[1] ? SSD_CNT_COUNT_REG : SSD_CNT_ONE) : SSD_CNT_IMM};
    end else if (a == 8'hf9 || a == 8'hfd || a == 8'hfb) begin
      expect_dec = {1'b0, a[2] ? SSD_OP_SET_DIR : (a[1] ? SSD_OP_SET_INTEN :
        SSD_OP_SET_CARRY), 4'h2, 3'h0, 8'h00};
    end else if (a[7:1] == 7'h55) begin
      em = 28'hffffff0;
      expect_dec = {1'b0, SSD_OP_STRING_WR, 4'h5, 3'h0, 1'b1, w, 4'h0};
    end else if (a[7:2] == 6'h0a) begin
      em = 28'hffffff0;
      expect_dec = {1'b0, SSD_OP_SUB, rg ? 4'h1 : 4'h3 - {3'h0, a[1]},
        rg ? 3'h0 : (a[1] | l ? 3'h2 : 3'h6), !rg, w, 4'h0};
    end
  endfunction
  // idle steps keep the old expectation, so held outputs are compared too
  task automatic step(input logic v, input logic [7:0] a, b, c, input logic s, l,
    input logic [2:0] fc);
    instValid = v;
    opByte0 = a;
    opByte1 = b;
    opByte2 = c;
    opSize32 = s;
    lockPrefix = l;
    flagClear = fc;
    if (v) ev = expect_dec(a, b, c, s, l);
    if (v) ei = (a == 8'h0f && b == 8'hac) || (a[7:1] == 7'h60 && b[5:3] == 3'h5);
    fl = (fl & ~fc) | (v ? {a == 8'hfb, a == 8'hfd, a == 8'hf9} : 3'h0);
    @(posedge core_clk);
    #2;
    got = {decValid_reg, decIllegal_reg, opClass_reg, hitClocks_reg, missPenalty_reg,
      memOperand_reg, opSize_reg, countSrc_reg};
    chk(got & {1'b1, em}, {v, em & ev});
    chk({28'h0, imm8Follows_reg}, {28'h0, ei});
    chk_flags({intEnableFlag_reg, directionFlag_reg, carryFlag_reg}, fl);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 1000) begin
      miscompares++;
      final_report;
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    #2;
    rst = 1'b0;
    for (int i = 0; i < 15; i++) begin
      step(1'b1, CORNER[i][23:16], CORNER[i][15:8], CORNER[i][7:0], i[1], i[0], 3'h7);
    end
    step(1'b0, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 3'h0);
    $display("test corner done");
    // mid-run reset: every decode output and flag must return to its idle value
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #2;
    rst = 1'b0;
    fl = 3'h0;
    ei = 1'b0;
    em = 28'hfffffff;
    ev = {1'b0, SSD_OP_NONE, 4'h1, 3'h0, 1'b0, SSD_SZ_BYTE, SSD_CNT_NONE};
    step(1'b0, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 3'h0);
    $display("test reset done");
    for (int i = 0; i < 600; i++) begin
      r = xs();
      pa = OPS[r[4:0] % 5'd17];
      pb = (pa == 8'h0f) ? ESC2[r[10:8] % 3'd5] : r[15:8];
      step(r[7:5] != 3'h0, pa, pb, r[23:16], r[24], r[25], r[28:26] == 3'h0 ? r[31:29] : 3'h0);
    end
    $display("test random done");
    final_report;
  end
endmodule
`default_nettype wire

// ==== ssd_modrm_if.sv ====
`default_nettype none
interface ssd_modrm_if;
  logic [7:0] rawByte;
  logic isReg;
  logic [2:0] regSel;
  logic [2:0] rmSel;
  modport splitter (input rawByte, output isReg, output regSel, output rmSel);
  modport user (output rawByte, input isReg, input regSel, input rmSel);
endinterface
`default_nettype wire

// ==== ssd_modrm_split.sv ====
`default_nettype none
`include "ssd_cfg.svh"
module ssd_modrm_split (
  ssd_modrm_if.splitter mr // one address-specifier byte in, fields out
);
  assign mr.isReg = (mr.rawByte[7:6] == `SSD_MOD_REG);
  assign mr.regSel = mr.rawByte[5:3];
  assign mr.rmSel = mr.rawByte[2:0];
endmodule
`default_nettype wire

// ==== ssd_pkg.sv ====
`default_nettype none
package ssd_pkg;
  typedef enum logic [11:0] {
    SSD_OP_NONE = 12'h001,
    SSD_OP_RSHIFT = 12'h002,
    SSD_OP_DSHR = 12'h004,
    SSD_OP_INT_TABLE = 12'h008,
    SSD_OP_LOCAL_SEL = 12'h010,
    SSD_OP_MACHINE_WORD = 12'h020,
    SSD_OP_SET_CARRY = 12'h040,
    SSD_OP_SET_DIR = 12'h080,
    SSD_OP_SET_INTEN = 12'h100,
    SSD_OP_STRING_WR = 12'h200,
    SSD_OP_TASK_SEL = 12'h400,
    SSD_OP_SUB = 12'h800
  } ssd_op_t;

  typedef enum logic [3:0] {
    SSD_CNT_NONE = 4'h1,
    SSD_CNT_ONE = 4'h2,
    SSD_CNT_COUNT_REG = 4'h4,
    SSD_CNT_IMM = 4'h8
  } ssd_count_t;

  typedef enum logic [2:0] {
    SSD_SZ_BYTE = 3'h1,
    SSD_SZ_WORD = 3'h2,
    SSD_SZ_DWORD = 3'h4
  } ssd_size_t;
endpackage
`default_nettype wire
